// File: hdl/tpb_pkg.sv
// constants, field layouts and carrier types of the timer/pwm/buzzer unit
// assumes a 32-bit apb slave with byte addresses, one register per word
package tpb_pkg;
    localparam logic [7:0] OFF_TC1   = 8'h00;
    localparam logic [7:0] OFF_TC2   = 8'h04;
    localparam logic [7:0] OFF_HI    = 8'h08;
    localparam logic [7:0] OFF_LO    = 8'h0C;
    localparam logic [7:0] OFF_DA    = 8'h10;
    localparam logic [7:0] OFF_PBC   = 8'h14;
    localparam logic [7:0] OFF_DB    = 8'h18;
    localparam logic [7:0] OFF_BZ    = 8'h1C;
    localparam logic [7:0] OFF_PSCV  = 8'h20;
    localparam logic [7:0] OFF_IEN   = 8'h24;
    localparam logic [7:0] OFF_STAT  = 8'h28;
    localparam int         HI_RL_POS = 4;
    localparam int         HI_DB_POS = 2;
    localparam int         HI_DA_POS = 0;
    localparam logic [9:0] CNT_TOP   = 10'h3FF;
    localparam logic [9:0] CNT_RST   = 10'h3FF;
    localparam logic [4:0] TC1_RST   = 5'h00;
    localparam logic [5:0] TC2_RST   = 6'h08;
    localparam logic [5:0] HI_RST    = 6'h3F;
    localparam logic [9:0] DUTY_RST  = 10'h000;
    localparam logic [4:0] BZ_RST    = 5'h00;
    localparam int         INSTR_DIV = 2;

    typedef struct packed {
        logic oe;
        logic al;
        logic one_shot;
        logic reload_sel;
        logic enable;
    } tpb_tc1_t;

    typedef struct packed {
        logic       src;
        logic       edge_fall;
        logic       ps_en_n;
        logic [2:0] ps_sel;
    } tpb_tc2_t;

    typedef struct packed {
        logic       en;
        logic [3:0] fsel;
    } tpb_bz_t;

    typedef enum logic {
        TPB_RUN  = 1'b0,
        TPB_STOP = 1'b1
    } tpb_run_t;
endpackage

// File: hdl/tpb_unit.sv
// timer/pwm/buzzer unit: 10-bit down timer, prescaler, two pwm, buzzer
// assumes an apb master on pclk; the clock pin is asynchronous to pclk
// Summary of operation
// R1 - ten-bit down counter behind optional prescaler
// R2 - reload buffered, taken at underflow when enabled
// R3 - disabled timer loads on low byte write
// R4 - reading timer returns live count
// R5 - source: instruction clock or external pin
// R6 - edge select: one falling, zero rising
// R7 - prescaler active low enable, 1:2..1:256, readable
// R8 - one-shot counts once then stops
// R9 - non-stop restarts from reload or 0x3FF
// R10 - underflow sets flag, gated interrupt request
// R11 - flag sticks until firmware writes zero
// R12 - pwm a enable drives pin, polarity bit
// R13 - duty zero never active, ten bits
// R14 - firmware keeps duty within reload value
// R15 - pwm a duty applied at next underflow
// R16 - buzzer enable drives its pin
// R17 - buzzer source select and 1:2..1:256 divide
// R18 - pwm a wins shared pin over buzzer
// R19 - pwm b own enable, polarity, duty bits
// R20 - firmware mirrors timer settings into pwm b
// R21 - pwm b duty applied at next underflow
// R22 - active for first duty ticks of frame
`timescale 1ns/10ps
module tpb_unit #(
    parameter int INSTR_DIV = tpb_pkg::INSTR_DIV
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic [7:0]  paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        ext_timer_clock_pin,
    output logic             shared_pin_out,
    output logic             shared_pin_oe,
    output logic             pwm_b_pin_out,
    output logic             pwm_b_pin_oe,
    output logic             irq_out
);
    tpb_pkg::tpb_tc1_t tc1_r;
    tpb_pkg::tpb_tc2_t tc2_r;
    tpb_pkg::tpb_bz_t  bz_r;
    tpb_pkg::tpb_run_t run_st_r;
    logic [5:0]  hi_r;
    logic [9:0]  reload_r;
    logic [9:0]  count_r;
    logic [9:0]  elap_r;
    logic [9:0]  da_buf_r;
    logic [9:0]  da_eff_r;
    logic [9:0]  db_buf_r;
    logic [9:0]  db_eff_r;
    logic [1:0]  pb_ctl_r;
    logic [2:0]  pb_mirror_r;
    logic [7:0]  ps_r;
    logic [6:0]  bz_cnt_r;
    logic        bz_out_r;
    logic        flag_r;
    logic        ie_r;
    logic        gie_r;
    logic [7:0]  div_r;
    logic        ext_s1_r;
    logic        ext_s2_r;
    logic        ext_s3_r;
    logic        pready_r;
    logic        pslverr_r;
    logic [31:0] prdata_r;
    logic        sh_out_r;
    logic        sh_oe_r;
    logic        pb_out_r;
    logic        pb_oe_r;
    logic        irq_r;

    logic        setup;
    logic        wr;
    logic        lo_wr;
    logic        hit;
    logic [31:0] rd_nxt;
    logic        instr_tick;
    logic        rise;
    logic        fall;
    logic        src_tick;
    logic [8:0]  ps_mask;
    logic        ps_tick;
    logic        t_tick;
    logic        run;
    logic        uf;
    logic [7:0]  bz_mask;
    logic        bz_src;
    logic        act_a;
    logic        act_b;

    assign prdata         = prdata_r;
    assign pready         = pready_r;
    assign pslverr        = pslverr_r;
    assign shared_pin_out = sh_out_r;
    assign shared_pin_oe  = sh_oe_r;
    assign pwm_b_pin_out  = pb_out_r;
    assign pwm_b_pin_oe   = pb_oe_r;
    assign irq_out        = irq_r;

    // apb: answer one cycle after setup, writes act in the access cycle
    assign setup = psel & ~penable;
    assign wr    = psel & penable & pwrite & pready_r;
    assign lo_wr = wr & (paddr == tpb_pkg::OFF_LO);

    always_comb begin
        hit    = 1'b1;
        rd_nxt = 32'h0000_0000;
        unique case (paddr)
            tpb_pkg::OFF_TC1:  rd_nxt = {24'h0, tc1_r.oe, tc1_r.al, 3'h0,
                                        tc1_r.one_shot, tc1_r.reload_sel, tc1_r.enable};
            tpb_pkg::OFF_TC2:  rd_nxt = {26'h0, tc2_r};
            tpb_pkg::OFF_HI:   rd_nxt = {26'h0, hi_r};
            tpb_pkg::OFF_LO:   rd_nxt = {22'h0, count_r}; // R4
            tpb_pkg::OFF_DA:   rd_nxt = 32'h0000_0000;
            tpb_pkg::OFF_PBC:  rd_nxt = {24'h0, pb_ctl_r, 3'h0, pb_mirror_r};
            tpb_pkg::OFF_DB:   rd_nxt = 32'h0000_0000;
            tpb_pkg::OFF_BZ:   rd_nxt = {24'h0, bz_r.en, 3'h0, bz_r.fsel};
            tpb_pkg::OFF_PSCV: rd_nxt = {24'h0, ps_r}; // R7
            tpb_pkg::OFF_IEN:  rd_nxt = {30'h0, gie_r, ie_r};
            tpb_pkg::OFF_STAT: rd_nxt = {31'h0, flag_r};
            default:           hit = 1'b0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= 32'h0000_0000;
        end else begin
            pready_r  <= setup;
            pslverr_r <= setup & ~hit;
            prdata_r  <= (setup & ~pwrite) ? rd_nxt : 32'h0000_0000;
        end
    end

    // configuration registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tc1_r       <= tpb_pkg::TC1_RST;
            tc2_r       <= tpb_pkg::TC2_RST;
            hi_r        <= tpb_pkg::HI_RST;
            pb_ctl_r    <= 2'h0;
            pb_mirror_r <= 3'h0;
            bz_r        <= tpb_pkg::BZ_RST;
            ie_r        <= 1'b0;
            gie_r       <= 1'b0;
        end else if (wr) begin
            if (paddr == tpb_pkg::OFF_TC1)
                tc1_r <= {pwdata[7:6], pwdata[2:0]};
            if (paddr == tpb_pkg::OFF_TC2)
                tc2_r <= pwdata[5:0];
            if (paddr == tpb_pkg::OFF_HI)
                hi_r <= pwdata[5:0];
            if (paddr == tpb_pkg::OFF_PBC) begin
                pb_ctl_r    <= pwdata[7:6];
                pb_mirror_r <= pwdata[2:0];
            end
            if (paddr == tpb_pkg::OFF_BZ)
                bz_r <= {pwdata[7], pwdata[3:0]};
            if (paddr == tpb_pkg::OFF_IEN) begin
                ie_r  <= pwdata[0];
                gie_r <= pwdata[1];
            end
        end
    end

    // double buffers: high bits first, the low byte write commits the word
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            reload_r <= tpb_pkg::CNT_RST;
            da_buf_r <= tpb_pkg::DUTY_RST;
            db_buf_r <= tpb_pkg::DUTY_RST;
        end else if (wr) begin
            if (paddr == tpb_pkg::OFF_LO)
                reload_r <= {hi_r[tpb_pkg::HI_RL_POS+:2], pwdata[7:0]}; // R2
            if (paddr == tpb_pkg::OFF_DA)
                da_buf_r <= {hi_r[tpb_pkg::HI_DA_POS+:2], pwdata[7:0]}; // R15
            if (paddr == tpb_pkg::OFF_DB)
                db_buf_r <= {hi_r[tpb_pkg::HI_DB_POS+:2], pwdata[7:0]}; // R19 R21
        end
    end

    // instruction clock enable derived from pclk
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            div_r <= 8'h00;
        else if (div_r == 8'(INSTR_DIV - 1))
            div_r <= 8'h00;
        else
            div_r <= div_r + 8'h01;
    end
    assign instr_tick = (div_r == 8'(INSTR_DIV - 1));

    // pin synchroniser; edges are taken only from the second and third stage
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_s1_r <= 1'b0;
            ext_s2_r <= 1'b0;
            ext_s3_r <= 1'b0;
        end else begin
            ext_s1_r <= ext_timer_clock_pin;
            ext_s2_r <= ext_s1_r;
            ext_s3_r <= ext_s2_r;
        end
    end
    assign rise = ext_s2_r & ~ext_s3_r;
    assign fall = ~ext_s2_r & ext_s3_r;

    always_comb begin
        src_tick = 1'b0;
        if (tc1_r.enable) // R5
            src_tick = tc2_r.src ? (tc2_r.edge_fall ? fall : rise) : instr_tick; // R6
    end

    // prescaler: 2^(sel+1) source ticks per output tick
    assign ps_mask = (9'h002 << tc2_r.ps_sel) - 9'h001;
    assign ps_tick = src_tick & ((ps_r & ps_mask[7:0]) == ps_mask[7:0]);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            ps_r <= 8'h00;
        else if (src_tick & ~tc2_r.ps_en_n)
            ps_r <= ps_r + 8'h01; // R7
    end

    assign t_tick = tc2_r.ps_en_n ? src_tick : ps_tick; // R1 R7
    assign run    = tc1_r.enable & (run_st_r == tpb_pkg::TPB_RUN);
    assign uf     = t_tick & run & (count_r == 10'h000);

    // one-shot stop state, re-armed by any OFF_TC1 write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            run_st_r <= tpb_pkg::TPB_RUN;
        else if (wr & (paddr == tpb_pkg::OFF_TC1))
            run_st_r <= tpb_pkg::TPB_RUN;
        else if (uf & tc1_r.one_shot)
            run_st_r <= tpb_pkg::TPB_STOP; // R8
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_r <= tpb_pkg::CNT_RST;
        end else if (lo_wr & ~tc1_r.enable) begin
            count_r <= {hi_r[tpb_pkg::HI_RL_POS+:2], pwdata[7:0]}; // R3
        end else if (uf) begin
            if (tc1_r.one_shot)
                count_r <= 10'h000; // R8
            else
                count_r <= tc1_r.reload_sel ? reload_r : tpb_pkg::CNT_TOP; // R2 R9
        end else if (t_tick & run) begin
            count_r <= count_r - 10'h001; // R1
        end
    end

    // ticks since the frame began, saturating so a long frame cannot wrap
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            elap_r <= 10'h000;
        else if (uf | (lo_wr & ~tc1_r.enable))
            elap_r <= 10'h000;
        else if (t_tick & run & (elap_r != tpb_pkg::CNT_TOP))
            elap_r <= elap_r + 10'h001;
    end

    // duties are taken at underflow; a disabled timer takes them at once
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            da_eff_r <= tpb_pkg::DUTY_RST;
            db_eff_r <= tpb_pkg::DUTY_RST;
        end else if (uf | ~tc1_r.enable) begin
            da_eff_r <= da_buf_r; // R15
            db_eff_r <= db_buf_r; // R21
        end
    end

    assign act_a = elap_r < da_eff_r; // R13 R22
    assign act_b = elap_r < db_eff_r; // R22

    // underflow flag: a new underflow beats a same-cycle clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            flag_r <= 1'b0;
        else if (uf)
            flag_r <= 1'b1; // R10
        else if (wr & (paddr == tpb_pkg::OFF_STAT) & ~pwdata[0])
            flag_r <= 1'b0; // R11
    end

    // buzzer: toggle every 2^fsel[2:0] source ticks gives 1:2 to 1:256
    assign bz_mask = (8'h01 << bz_r.fsel[2:0]) - 8'h01;
    assign bz_src  = bz_r.fsel[3] ? uf : ps_tick; // R17

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bz_cnt_r <= 7'h00;
            bz_out_r <= 1'b0;
        end else if (bz_src) begin
            bz_cnt_r <= bz_cnt_r + 7'h01;
            if ((bz_cnt_r & bz_mask[6:0]) == bz_mask[6:0])
                bz_out_r <= ~bz_out_r; // R17
        end
    end

    // pins and request, all registered
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sh_out_r <= 1'b0;
            sh_oe_r  <= 1'b0;
            pb_out_r <= 1'b0;
            pb_oe_r  <= 1'b0;
            irq_r    <= 1'b0;
        end else begin
            if (tc1_r.oe)
                sh_out_r <= act_a ^ tc1_r.al; // R12 R18
            else
                sh_out_r <= bz_r.en & bz_out_r; // R16
            sh_oe_r  <= tc1_r.oe | bz_r.en; // R12 R16
            pb_out_r <= pb_ctl_r[1] & (act_b ^ pb_ctl_r[0]); // R19
            pb_oe_r  <= pb_ctl_r[1]; // R19
            irq_r    <= flag_r & ie_r & gie_r; // R10
        end
    end

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_oneshot_uf;
        uf && tc1_r.one_shot;
    endsequence

    sequence s_held_stop;
        (run_st_r == tpb_pkg::TPB_STOP && count_r == 10'h000) [*2];
    endsequence

    a_flag_on_uf: assert property (uf |=> flag_r) // R10
        else $error("underflow did not set flag");
    a_flag_sticky: assert property (flag_r && !(wr && paddr == tpb_pkg::OFF_STAT) ##1 1 |-> flag_r) // R11
        else $error("flag cleared without firmware");
    a_irq_gate: assert property (flag_r && ie_r && gie_r |=> irq_out) // R10
        else $error("irq not raised");
    a_imm_load: assert property (lo_wr && !tc1_r.enable |=> count_r == reload_r // R3
                                 && count_r[7:0] == $past(pwdata[7:0]))
        else $error("disabled timer did not load");
    a_hold_buffer: assert property (lo_wr && tc1_r.enable && !t_tick |=> count_r == $past(count_r)) // R2
        else $error("enabled counter took reload early");
    a_down_count: assert property (t_tick && run && count_r != 10'h000 && !lo_wr |=> count_r == $past(count_r) - 10'h001) // R1
        else $error("count did not decrement");
    a_top_restart: assert property (uf && !tc1_r.one_shot && !tc1_r.reload_sel && !lo_wr |=> count_r == 10'h3FF) // R9
        else $error("non-stop did not restart at top");
    a_rl_restart: assert property (uf && !tc1_r.one_shot && tc1_r.reload_sel && !lo_wr |=> count_r == $past(reload_r)) // R9
        else $error("non-stop did not restart from reload");
    a_oneshot_stop: assert property (s_oneshot_uf ##1 !wr |-> s_held_stop) // R8
        else $error("one-shot kept running");
    a_duty_latch: assert property (uf |=> da_eff_r == $past(da_buf_r) && db_eff_r == $past(db_buf_r)) // R15
        else $error("duty not applied at underflow");
    a_pin_priority: assert property (tc1_r.oe && bz_r.en |=> shared_pin_oe && shared_pin_out == $past(act_a ^ tc1_r.al)) // R18
        else $error("buzzer took pin from pwm");
    a_zero_duty: assert property (tc1_r.oe && !tc1_r.al && da_eff_r == 10'h000 |=> !shared_pin_out) // R13
        else $error("zero duty went active");
    a_buzz_pin: assert property (bz_r.en && !tc1_r.oe |=> shared_pin_oe && shared_pin_out == $past(bz_out_r)) // R16
        else $error("buzzer not on pin");
    a_read_count: assert property (setup && !pwrite && paddr == tpb_pkg::OFF_LO |=> prdata == {22'h0, $past(count_r)}) // R4
        else $error("read did not return count");
endmodule

// File: tb/tb_timer_pwm_buzzer_unit.sv
// self-checking bench for the timer/pwm/buzzer unit
// assumes the unit answers apb in one access cycle; pin outputs come from flops
`timescale 1ns/10ps
module tb_timer_pwm_buzzer_unit;
    typedef struct {logic [7:0] a; logic [31:0] d; logic e;} tpb_row_t;
    logic        pclk, presetn, psel, penable, pwrite, ext_timer_clock_pin;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, q;
    logic        pready, pslverr, shared_pin_out, shared_pin_oe, pwm_b_pin_out, pwm_b_pin_oe, irq_out, e;
    int          num_errors, cmp_count, ha, hb;
    tpb_row_t    rows [11];

    tpb_unit #(.INSTR_DIV(2)) DUT (
        .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .ext_timer_clock_pin(ext_timer_clock_pin), .shared_pin_out(shared_pin_out),
        .shared_pin_oe(shared_pin_oe), .pwm_b_pin_out(pwm_b_pin_out), .pwm_b_pin_oe(pwm_b_pin_oe),
        .irq_out(irq_out));

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    task chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    // request held until pready is sampled high; no fixed latency assumed
    task xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) chk(1'b0, 1'b1, "pready");
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d);
        xfer(a, 1'b1, d);
    endtask

    task meas(input int n);
        ha = 0;
        hb = 0;
        repeat (n) begin
            @(posedge pclk);
            if ($isunknown({shared_pin_out, pwm_b_pin_out})) chk(1'b0, 1'b1, "unknown pin level");
            ha += (shared_pin_out === 1'b1);
            hb += (pwm_b_pin_out === 1'b1);
        end
    endtask

    task pulses(input int n);
        repeat (n) begin
            @(posedge pclk) ext_timer_clock_pin <= 1'b1;
            repeat (6) @(posedge pclk);
            ext_timer_clock_pin <= 1'b0;
            repeat (6) @(posedge pclk);
        end
        ext_timer_clock_pin <= 1'b1;
        repeat (8) @(posedge pclk);
    endtask

    task done(input string name);
        $display("test %s finished", name);
    endtask

    task results;
        $display("comparisons %0d, mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    initial begin
        #600000;
        num_errors++;
        results();
    end

    initial begin
        num_errors = 0;
        cmp_count = 0;
        presetn = 1'b0;
        {psel, penable, pwrite, ext_timer_clock_pin} = 4'h0;
        paddr = 8'h00;
        pwdata = 32'h0;
        rows = '{'{tpb_pkg::OFF_TC1, 32'h0, 1'b0}, '{tpb_pkg::OFF_TC2, 32'h8, 1'b0},
                 '{tpb_pkg::OFF_HI, 32'h3F, 1'b0}, '{tpb_pkg::OFF_LO, 32'h3FF, 1'b0},
                 '{tpb_pkg::OFF_DA, 32'h0, 1'b0}, '{tpb_pkg::OFF_BZ, 32'h0, 1'b0},
                 '{tpb_pkg::OFF_IEN, 32'h0, 1'b0}, '{tpb_pkg::OFF_STAT, 32'h0, 1'b0},
                 '{8'h30, 32'h0, 1'b1}, '{tpb_pkg::OFF_PSCV, 32'h0, 1'b0},
                 '{tpb_pkg::OFF_PBC, 32'h0, 1'b0}};
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        foreach (rows[i]) begin
            xfer(rows[i].a, 1'b0, 32'h0);
            chk(q, rows[i].d, "reset read");
            chk(e, rows[i].e, "slave error");
        end
        chk({shared_pin_oe, pwm_b_pin_oe, irq_out}, 3'b000, "idle pins");
        done("reset");
        // disabled timer takes the reload as soon as the low byte lands
        wr(tpb_pkg::OFF_HI, 32'h10);
        wr(tpb_pkg::OFF_LO, 32'h05);
        xfer(tpb_pkg::OFF_LO, 1'b0, 32'h0);
        chk(q, 32'h105, "direct load");
        wr(tpb_pkg::OFF_HI, 32'h00);
        wr(tpb_pkg::OFF_LO, 32'h03);
        wr(tpb_pkg::OFF_TC1, 32'h05);
        repeat (30) @(posedge pclk);
        xfer(tpb_pkg::OFF_LO, 1'b0, 32'h0);
        chk(q, 32'h0, "one-shot stop");
        xfer(tpb_pkg::OFF_STAT, 1'b0, 32'h0);
        chk(q, 32'h1, "flag set");
        wr(tpb_pkg::OFF_IEN, 32'h3);
        repeat (3) @(posedge pclk);
        chk(irq_out, 1'b1, "irq raised");
        wr(tpb_pkg::OFF_IEN, 32'h1);
        repeat (3) @(posedge pclk);
        chk(irq_out, 1'b0, "global gate");
        wr(tpb_pkg::OFF_IEN, 32'h3);
        wr(tpb_pkg::OFF_STAT, 32'h0);
        repeat (3) @(posedge pclk);
        chk(irq_out, 1'b0, "irq cleared");
        xfer(tpb_pkg::OFF_STAT, 1'b0, 32'h0);
        chk(q, 32'h0, "flag cleared");
        done("one-shot");
        wr(tpb_pkg::OFF_TC1, 32'h01);
        repeat (12) @(posedge pclk);
        xfer(tpb_pkg::OFF_LO, 1'b0, 32'h0);
        chk(q[9:4], 6'h3F, "restart at top");
        wr(tpb_pkg::OFF_LO, 32'h05);
        xfer(tpb_pkg::OFF_LO, 1'b0, 32'h0);
        chk(q[9:8], 2'b11, "reload buffered");
        wr(tpb_pkg::OFF_TC1, 32'h03);
        repeat (2100) @(posedge pclk);
        xfer(tpb_pkg::OFF_LO, 1'b0, 32'h0);
        chk(q <= 32'h5, 1'b1, "restart at reload");
        done("non-stop");
        // external pin: six rising and five falling edges per burst
        for (int f = 0; f < 2; f++) begin
            wr(tpb_pkg::OFF_TC1, 32'h00);
            ext_timer_clock_pin <= 1'b0;
            wr(tpb_pkg::OFF_HI, 32'h10);
            wr(tpb_pkg::OFF_LO, 32'h00);
            wr(tpb_pkg::OFF_TC2, 32'h28 | (f << 4));
            wr(tpb_pkg::OFF_TC1, 32'h01);
            pulses(5);
            wr(tpb_pkg::OFF_TC1, 32'h00);
            xfer(tpb_pkg::OFF_LO, 1'b0, 32'h0);
            chk(q, 32'h0FA + f, "pin edges");
        end
        done("external clock");
        // frame of ten timer ticks, 20 pclk; measured windows span whole frames
        wr(tpb_pkg::OFF_TC2, 32'h08);
        wr(tpb_pkg::OFF_HI, 32'h00);
        wr(tpb_pkg::OFF_LO, 32'h09);
        wr(tpb_pkg::OFF_DA, 32'h03);
        wr(tpb_pkg::OFF_DB, 32'h05);
        wr(tpb_pkg::OFF_PBC, 32'h83);
        wr(tpb_pkg::OFF_TC1, 32'h83);
        repeat (40) @(posedge pclk);
        meas(200);
        chk(ha, 60, "pwm a active");
        chk(hb, 100, "pwm b active");
        chk({shared_pin_oe, pwm_b_pin_oe}, 2'b11, "pwm drive");
        wr(tpb_pkg::OFF_TC1, 32'hC3);
        wr(tpb_pkg::OFF_PBC, 32'hC3);
        repeat (40) @(posedge pclk);
        meas(200);
        chk(ha, 140, "pwm a low");
        chk(hb, 100, "pwm b low");
        wr(tpb_pkg::OFF_TC1, 32'h83);
        wr(tpb_pkg::OFF_DA, 32'h00);
        wr(tpb_pkg::OFF_BZ, 32'h88);
        repeat (60) @(posedge pclk);
        meas(200);
        chk(ha, 0, "zero duty over buzzer");
        wr(tpb_pkg::OFF_TC1, 32'h03);
        repeat (60) @(posedge pclk);
        meas(200);
        chk(ha, 100, "buzzer from underflow");
        chk(shared_pin_oe, 1'b1, "buzzer drive");
        done("pwm and buzzer");
        wr(tpb_pkg::OFF_BZ, 32'h00);
        wr(tpb_pkg::OFF_DA, 32'h03);
        wr(tpb_pkg::OFF_TC1, 32'h83);
        foreach (rows[r]) begin
            if (r == 3 || r == 8) begin
                wr(tpb_pkg::OFF_TC2, r == 8 ? 32'h7 : 32'h0 + (r / 3));
                repeat (40 << ((r == 8 ? 7 : r / 3) + 1)) @(posedge pclk);
                meas(40 << ((r == 8 ? 7 : r / 3) + 1));
                chk(ha, 12 << ((r == 8 ? 7 : r / 3) + 1), "prescaled duty");
            end
        end
        // buzzer from the 1:2 prescaler, toggling every second tick: 16 pclk period
        wr(tpb_pkg::OFF_TC2, 32'h00);
        wr(tpb_pkg::OFF_BZ, 32'h81);
        wr(tpb_pkg::OFF_TC1, 32'h03);
        repeat (40) @(posedge pclk);
        meas(160);
        chk(ha, 80, "buzzer from prescaler");
        done("prescaler");
        // reset in mid-run: pins drop at once, registers return to reset values
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        chk({shared_pin_oe, shared_pin_out, pwm_b_pin_oe, pwm_b_pin_out, irq_out}, 5'h00, "reset pins");
        presetn <= 1'b1;
        foreach (rows[i]) begin
            xfer(rows[i].a, 1'b0, 32'h0);
            chk(q, rows[i].d, "second reset read");
        end
        done("mid-run reset");
        results();
    end
endmodule
